// File: core/param_sram_pkg.sv
// Shared constants and types for the motion engine parameter bank.
// Assumes an 8-bit register port and a single 200 MHz system clock.
package param_sram_pkg;

  // Bus and storage shape
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 8;
  localparam int IDX_W     = 6;
  localparam int MEM_DEPTH = 64;

  // Factory trim byte offsets
  localparam logic [7:0] OFF_GYRO_Y_GAIN_HI  = 8'h09;
  localparam logic [7:0] OFF_GYRO_Z_GAIN_LO  = 8'h0a;
  localparam logic [7:0] OFF_GYRO_Z_GAIN_HI  = 8'h0b;
  localparam logic [7:0] OFF_ACCEL_X_ST_LO   = 8'h0c;
  localparam logic [7:0] OFF_ACCEL_X_ST_HI   = 8'h0d;
  localparam logic [7:0] OFF_ACCEL_Y_ST_LO   = 8'h0e;
  localparam logic [7:0] OFF_ACCEL_Y_ST_HI   = 8'h0f;
  localparam logic [7:0] OFF_ACCEL_Z_ST_LO   = 8'h10;
  localparam logic [7:0] OFF_ACCEL_Z_ST_HI   = 8'h11;

  // Output-rate byte offsets, low byte at the even address
  localparam logic [7:0] OFF_FREEFALL_LO     = 8'h2a;
  localparam logic [7:0] OFF_FREEFALL_HI     = 8'h2b;
  localparam logic [7:0] OFF_TAP_LO          = 8'h2c;
  localparam logic [7:0] OFF_TAP_HI          = 8'h2d;
  localparam logic [7:0] OFF_RAISE_WAKE_LO   = 8'h2e;
  localparam logic [7:0] OFF_RAISE_WAKE_HI   = 8'h2f;
  localparam logic [7:0] OFF_THREE_AXIS_LO   = 8'h30;
  localparam logic [7:0] OFF_THREE_AXIS_HI   = 8'h31;
  localparam logic [7:0] OFF_TILT_LO         = 8'h32;
  localparam logic [7:0] OFF_TILT_HI         = 8'h33;
  localparam logic [7:0] OFF_STEP_LO         = 8'h34;
  localparam logic [7:0] OFF_STEP_HI         = 8'h35;

  // Engine control and status
  localparam logic [7:0] OFF_ENGINE_STATUS   = 8'h40;
  localparam logic [7:0] OFF_ENGINE_CTRL     = 8'h41;
  localparam int         CTRL_START_BIT      = 0;
  localparam int         STATUS_DONE_BIT     = 0;
  localparam int         STATUS_BUSY_BIT     = 1;

  // Gain high byte keeps only its low nibble
  localparam logic [7:0] GAIN_HI_MASK        = 8'h0f;

  // Rate defaults written by the initialisation procedure
  localparam logic [15:0] DEF_FREEFALL_RATE  = 16'h0190;
  localparam logic [15:0] DEF_TAP_RATE       = 16'h0190;
  localparam logic [15:0] DEF_RAISE_WAKE_RATE = 16'h0019;
  localparam logic [15:0] DEF_THREE_AXIS_RATE = 16'h0032;
  localparam logic [15:0] DEF_TILT_RATE      = 16'h0032;
  localparam logic [15:0] DEF_STEP_RATE      = 16'h0032;
  localparam logic [3:0]  RATE_BYTES_LAST    = 4'hb;

  // Values presented to the motion engine
  typedef struct packed {
    logic [11:0]        gyro_y_gain_trim;
    logic [11:0]        gyro_z_gain_trim;
    logic signed [15:0] accel_x_selftest_response;
    logic signed [15:0] accel_y_selftest_response;
    logic signed [15:0] accel_z_selftest_response;
    logic signed [15:0] freefall_rate;
    logic signed [15:0] tap_rate;
    logic signed [15:0] raise_wake_rate;
    logic signed [15:0] three_axis_rate;
    logic signed [15:0] tilt_rate;
    logic signed [15:0] step_counter_rate;
  } engine_params_s;

  // Initialisation sequencer
  typedef enum logic [1:0] {
    INIT_IDLE,
    INIT_LOAD,
    INIT_DONE
  } init_state_e;

endpackage

// File: core/param_sram_array.sv
// Byte-wide on-chip storage for the parameter bank.
// Assumes one write port and an asynchronous read port on the same clock.
`timescale 1ns/1ps
module param_sram_array
  import param_sram_pkg::*;
(
  // Clock and enable
  input  wire logic              sys_clk_in,
  input  wire logic              ce_in,
  // Write port
  input  wire logic              wr_en_in,
  input  wire logic [IDX_W-1:0]  wr_idx_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  // Read port
  input  wire logic [IDX_W-1:0]  rd_idx_in,
  output logic      [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // Storage has no reset, so contents are random until loaded
  always_ff @(posedge sys_clk_in) begin
    if (ce_in && wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  // Read is combinational; the caller registers it
  assign rd_data_out = mem[rd_idx_in];

endmodule

// File: core/motion_engine_param_sram_regs.sv
// Motion engine parameter bank: factory trims and output-rate settings.
// Assumes a byte register port on sys_clk_in and a host that runs init.
//
// Overview of operation
// R01 - Bank contents undefined after reset until init
// R02 - All bank storage clocked by main clock only
// R03 - Gyro Y/Z gain: twelve bits, split bytes
// R04 - Accel self-test: sixteen bits, low byte first
// R05 - Rates: signed sixteen bits, low at even
// R06 - Free-fall rate defaults to 400 Hz
// R07 - Tap rate defaults to 400 Hz
// R08 - Raise-to-wake rate defaults to 25 Hz
// R09 - Three-axis rate defaults to 50 Hz
// R10 - Tilt rate defaults to 50 Hz
// R11 - Step counter rate at 0x34, 50 Hz
// R12 - Host leaves fields alone while sensor runs
// R13 - Gain reserved nibble reads zero, ignores writes
`timescale 1ns/1ps
module motion_engine_param_sram_regs
  import param_sram_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              ce_in,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  // Engine side
  output engine_params_s         params_out,
  output logic                   init_done_out
);

  // Address is one of the bank's storage bytes
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = ((a >= OFF_GYRO_Y_GAIN_HI) && (a <= OFF_ACCEL_Z_ST_HI)) ||
                ((a >= OFF_FREEFALL_LO) && (a <= OFF_STEP_HI));
  endfunction

  // Address is a gain high byte with a reserved nibble
  function automatic logic is_gain_hi(input logic [ADDR_W-1:0] a);
    is_gain_hi = (a == OFF_GYRO_Y_GAIN_HI) || (a == OFF_GYRO_Z_GAIN_HI);
  endfunction

  // Default byte for rate slot idx, low byte first
  function automatic logic [7:0] rate_default_byte(input logic [3:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx[3:1])
      3'h0:    v = DEF_FREEFALL_RATE;
      3'h1:    v = DEF_TAP_RATE;
      3'h2:    v = DEF_RAISE_WAKE_RATE;
      3'h3:    v = DEF_THREE_AXIS_RATE;
      3'h4:    v = DEF_TILT_RATE;
      3'h5:    v = DEF_STEP_RATE;
      default: v = 16'h0000;
    endcase
    rate_default_byte = idx[0] ? v[15:8] : v[7:0];
  endfunction

  // Reset release through two flops
  logic rst_meta_r;
  logic rst_b;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_b      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b      <= rst_meta_r;
    end
  end

  // Sequencer state
  init_state_e       state_r;
  logic [3:0]        load_idx_r;
  logic              init_done_r;
  logic              start_init;
  logic              loading;

  // Shared write port
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              host_wr_ok;
  logic [DATA_W-1:0] mem_rd_data;

  // Read data and shadow copy
  logic [DATA_W-1:0] rdata_r;
  engine_params_s    params_r;

  assign loading    = (state_r == INIT_LOAD);
  assign start_init = reg_wr_in && (reg_addr_in == OFF_ENGINE_CTRL) &&
                      reg_wdata_in[CTRL_START_BIT] && !loading;
  // Host bank writes are dropped while defaults load
  assign host_wr_ok = reg_wr_in && is_mapped(reg_addr_in) && !loading;

  // Write source: sequencer while loading, host otherwise
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = reg_addr_in;
    wr_data = reg_wdata_in;
    if (loading) begin
      wr_en   = 1'b1;
      wr_addr = OFF_FREEFALL_LO + {4'h0, load_idx_r};   // [R05]
      wr_data = rate_default_byte(load_idx_r);          // [R06] [R07] [R08] [R09] [R10] [R11]
    end else if (host_wr_ok) begin
      wr_en = 1'b1;
      if (is_gain_hi(reg_addr_in)) begin
        wr_data = reg_wdata_in & GAIN_HI_MASK;          // [R13]
      end
    end
  end

  // Storage array, no reset, written only on sys_clk_in
  param_sram_array u_array (
    .sys_clk_in  (sys_clk_in),
    .ce_in       (ce_in),
    .wr_en_in    (wr_en),                               // [R02]
    .wr_idx_in   (wr_addr[IDX_W-1:0]),                  // [R01]
    .wr_data_in  (wr_data),
    .rd_idx_in   (reg_addr_in[IDX_W-1:0]),
    .rd_data_out (mem_rd_data)
  );

  // Initialisation sequencer
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= INIT_IDLE;
      load_idx_r <= 4'h0;
    end else if (ce_in) begin
      case (state_r)
        INIT_IDLE, INIT_DONE: begin
          if (start_init) begin
            state_r    <= INIT_LOAD;
            load_idx_r <= 4'h0;
          end
        end
        INIT_LOAD: begin
          if (load_idx_r == RATE_BYTES_LAST) begin
            state_r <= INIT_DONE;
          end else begin
            load_idx_r <= load_idx_r + 4'h1;
          end
        end
        default: begin
          state_r <= INIT_IDLE;
        end
      endcase
    end
  end

  // Done flag: cleared by a new start, set on the last default byte
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      init_done_r <= 1'b0;
    end else if (ce_in) begin
      if (loading && (load_idx_r == RATE_BYTES_LAST)) begin
        init_done_r <= 1'b1;
      end else if (start_init) begin
        init_done_r <= 1'b0;                            // [R01]
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (ce_in) begin
      if (!reg_rd_in) begin
        rdata_r <= 8'h00;
      end else if (reg_addr_in == OFF_ENGINE_STATUS) begin
        rdata_r <= {6'h00, loading, init_done_r};
      end else if (reg_addr_in == OFF_ENGINE_CTRL) begin
        rdata_r <= 8'h00;
      end else if (is_gain_hi(reg_addr_in)) begin
        rdata_r <= mem_rd_data & GAIN_HI_MASK;          // [R13]
      end else if (is_mapped(reg_addr_in)) begin
        rdata_r <= mem_rd_data;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // Shadow of the bank for the engine; unreset like the storage
  always_ff @(posedge sys_clk_in) begin
    if (ce_in && wr_en) begin
      case (wr_addr)
        OFF_GYRO_Y_GAIN_HI: params_r.gyro_y_gain_trim[11:8] <= wr_data[3:0];   // [R03]
        OFF_GYRO_Z_GAIN_LO: params_r.gyro_z_gain_trim[7:0]  <= wr_data;        // [R03]
        OFF_GYRO_Z_GAIN_HI: params_r.gyro_z_gain_trim[11:8] <= wr_data[3:0];   // [R03]
        OFF_ACCEL_X_ST_LO:  params_r.accel_x_selftest_response[7:0]  <= wr_data; // [R04]
        OFF_ACCEL_X_ST_HI:  params_r.accel_x_selftest_response[15:8] <= wr_data; // [R04]
        OFF_ACCEL_Y_ST_LO:  params_r.accel_y_selftest_response[7:0]  <= wr_data; // [R04]
        OFF_ACCEL_Y_ST_HI:  params_r.accel_y_selftest_response[15:8] <= wr_data; // [R04]
        OFF_ACCEL_Z_ST_LO:  params_r.accel_z_selftest_response[7:0]  <= wr_data; // [R04]
        OFF_ACCEL_Z_ST_HI:  params_r.accel_z_selftest_response[15:8] <= wr_data; // [R04]
        OFF_FREEFALL_LO:    params_r.freefall_rate[7:0]      <= wr_data;       // [R05]
        OFF_FREEFALL_HI:    params_r.freefall_rate[15:8]     <= wr_data;       // [R05]
        OFF_TAP_LO:         params_r.tap_rate[7:0]           <= wr_data;
        OFF_TAP_HI:         params_r.tap_rate[15:8]          <= wr_data;
        OFF_RAISE_WAKE_LO:  params_r.raise_wake_rate[7:0]    <= wr_data;
        OFF_RAISE_WAKE_HI:  params_r.raise_wake_rate[15:8]   <= wr_data;
        OFF_THREE_AXIS_LO:  params_r.three_axis_rate[7:0]    <= wr_data;
        OFF_THREE_AXIS_HI:  params_r.three_axis_rate[15:8]   <= wr_data;
        OFF_TILT_LO:        params_r.tilt_rate[7:0]          <= wr_data;
        OFF_TILT_HI:        params_r.tilt_rate[15:8]         <= wr_data;
        OFF_STEP_LO:        params_r.step_counter_rate[7:0]  <= wr_data;       // [R11]
        OFF_STEP_HI:        params_r.step_counter_rate[15:8] <= wr_data;
        default:            params_r.gyro_y_gain_trim[7:0]   <= params_r.gyro_y_gain_trim[7:0];
      endcase
    end
  end

  // The low gain Y byte sits just below this bank; it is kept in the shadow only
  // so the twelve-bit field is whole, and stays random until written elsewhere.

  // Outputs straight from flops
  assign reg_rdata_out = rdata_r;
  assign params_out    = params_r;
  assign init_done_out = init_done_r;

  // Checks

  // Done stays low until a start is seen
  a_done_needs_start: assert property (                                     // [R01]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (!init_done_r && !start_init && !loading) |=> !init_done_r)
    else $error("done rose without an init start");

  // Nothing moves with the enable low
  a_freeze_on_ce: assert property (                                         // [R02]
    @(posedge sys_clk_in) disable iff (!rst_b)
    !ce_in |=> ($stable(params_r[$bits(engine_params_s)-13:0]) && $stable(params_r.gyro_y_gain_trim[11:8]) &&
                $stable(state_r) && $stable(rdata_r) && $stable(init_done_r)))
    else $error("state changed while enable low");

  // Gain high write lands in the top nibble of the trim
  a_gain_hi_write: assert property (                                        // [R03]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && host_wr_ok && reg_addr_in == OFF_GYRO_Z_GAIN_HI)
    |=> params_r.gyro_z_gain_trim[11:8] == $past(reg_wdata_in[3:0]))
    else $error("gyro z gain high nibble not stored");

  // Accel high byte lands in bits 15:8
  a_accel_hi_write: assert property (                                       // [R04]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && host_wr_ok && reg_addr_in == OFF_ACCEL_X_ST_HI)
    |=> params_r.accel_x_selftest_response[15:8] == $past(reg_wdata_in))
    else $error("accel x high byte not stored");

  // Rate low byte written then read back matches
  a_rate_readback: assert property (                                        // [R05]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && host_wr_ok && reg_addr_in == OFF_TILT_LO) ##1
    (ce_in && reg_rd_in && !reg_wr_in && !loading && reg_addr_in == OFF_TILT_LO)
    |=> rdata_r == $past(reg_wdata_in, 2))
    else $error("tilt rate low byte read back wrong");

  // Defaults in place when done rises
  a_free_tap_def: assert property (                                         // [R06] [R07]
    @(posedge sys_clk_in) disable iff (!rst_b)
    $rose(init_done_r) |->
    (params_r.freefall_rate == DEF_FREEFALL_RATE) && (params_r.tap_rate == DEF_TAP_RATE))
    else $error("free-fall or tap default wrong");

  a_wake_axis_def: assert property (                                        // [R08] [R09]
    @(posedge sys_clk_in) disable iff (!rst_b)
    $rose(init_done_r) |->
    (params_r.raise_wake_rate == DEF_RAISE_WAKE_RATE) &&
    (params_r.three_axis_rate == DEF_THREE_AXIS_RATE))
    else $error("raise-to-wake or three-axis default wrong");

  a_tilt_step_def: assert property (                                        // [R10] [R11]
    @(posedge sys_clk_in) disable iff (!rst_b)
    $rose(init_done_r) |->
    (params_r.tilt_rate == DEF_TILT_RATE) && (params_r.step_counter_rate == DEF_STEP_RATE))
    else $error("tilt or step rate default wrong");

  // Load takes exactly twelve enabled cycles
  a_load_length: assert property (                                          // [R06]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && start_init) ##1 ce_in [*8] ##1 ce_in [*4] |=> init_done_r)
    else $error("default load did not finish in twelve cycles");

  // Reserved nibble reads as zero
  a_gain_rsvd_zero: assert property (                                       // [R13]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && reg_rd_in && is_gain_hi(reg_addr_in)) |=> rdata_r[7:4] == 4'h0)
    else $error("reserved gain bits not zero");

  // A start clears done and begins at the first rate byte
  a_start_enters_load: assert property (                                    // [R01]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && start_init) |=> (loading && (load_idx_r == 4'h0) && !init_done_r))
    else $error("start did not begin the default load");

  // Done never shows while defaults are still loading
  a_busy_not_done: assert property (                                        // [R01]
    @(posedge sys_clk_in) disable iff (!rst_b)
    loading |-> !init_done_r)
    else $error("done high during default load");

  // Load walks the rate bytes one per enabled cycle
  a_load_addr_walk: assert property (                                       // [R05]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && loading && (load_idx_r != RATE_BYTES_LAST))
    |=> (loading && (load_idx_r == $past(load_idx_r) + 4'h1)))
    else $error("load index did not step by one");

  // Load index never passes the last rate byte
  a_load_idx_bound: assert property (                                       // [R11]
    @(posedge sys_clk_in) disable iff (!rst_b)
    loading |-> (load_idx_r <= RATE_BYTES_LAST))
    else $error("load index past last rate byte");

  // Sequencer writes land only inside the rate bytes
  a_load_write_range: assert property (                                     // [R05]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && loading) |-> (wr_en && (wr_addr >= OFF_FREEFALL_LO) && (wr_addr <= OFF_STEP_HI)))
    else $error("default load wrote outside the rate bytes");

  // Reserved gain nibble is never stored
  a_gain_store_mask: assert property (                                      // [R13]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && wr_en && is_gain_hi(wr_addr)) |-> (wr_data[7:4] == 4'h0))
    else $error("reserved gain bits reached storage");

  // Read data falls back to zero without a read strobe
  a_rdata_idle_zero: assert property (                                      // [R05]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && !reg_rd_in) |=> (rdata_r == 8'h00))
    else $error("read data held without a read");

  // Rate high byte lands in bits 15:8
  a_tilt_hi_write: assert property (                                        // [R05]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && host_wr_ok && reg_addr_in == OFF_TILT_HI)
    |=> params_r.tilt_rate[15:8] == $past(reg_wdata_in))
    else $error("tilt rate high byte not stored");

  // Gain low byte lands in bits 7:0
  a_trim_lo_write: assert property (                                        // [R03]
    @(posedge sys_clk_in) disable iff (!rst_b)
    (ce_in && host_wr_ok && reg_addr_in == OFF_GYRO_Z_GAIN_LO)
    |=> params_r.gyro_z_gain_trim[7:0] == $past(reg_wdata_in))
    else $error("gyro z gain low byte not stored");

endmodule

// File: verif/tb_motion_engine_param_sram_regs.sv
// Self-checking bench for the motion engine parameter bank.
// Assumes the bench alone drives the register port, clock enable and reset.
`timescale 1ns/1ps
module tb_motion_engine_param_sram_regs import param_sram_pkg::*;;

  // Compare one value and count it
  `define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin num_errors++; \
    $display("ERROR t=%0t mismatch got %h expected %h", $time, (act), (exp)); end end

  logic                  sys_clk_in;
  logic                  rst_b_in;
  logic                  ce_in;
  logic [ADDR_W-1:0]     reg_addr_in;
  logic [DATA_W-1:0]     reg_wdata_in;
  logic                  reg_wr_in;
  logic                  reg_rd_in;
  logic [DATA_W-1:0]     reg_rdata_out;
  engine_params_s        params_out;
  logic                  init_done_out;
  int                    num_errors;
  int                    n_checks;
  int                    cycles;
  logic [DATA_W-1:0]     rdv;
  logic [15:0]           defs [6];

  // One clock for every register of the bank
  initial sys_clk_in = 1'b0;
  always #2.5 sys_clk_in = ~sys_clk_in;

  motion_engine_param_sram_regs DUT (
    .sys_clk_in    (sys_clk_in),
    .rst_b_in      (rst_b_in),
    .ce_in         (ce_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .params_out    (params_out),
    .init_done_out (init_done_out)
  );

  // Final report and verdict
  task automatic complete_run();
    $display("Checks made: %0d, mismatches: %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("ERROR t=%0t run did not finish in time", $time);
      complete_run();
    end
  end

  // One-cycle write strobe; returns just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  // Write then read the same byte with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
    reg_rd_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in    <= 1'b0;
    #1;
    q = reg_rdata_out;
  endtask

  // Reset held for five cycles, then the synchroniser settles
  task automatic do_reset();
    @(posedge sys_clk_in);
    rst_b_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    `CHK(reg_rdata_out, 8'h00)
    `CHK(init_done_out, 1'b0)
    @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
  endtask

  // Wait for the defaults to land, bounded
  task automatic wait_init();
    int k;
    for (k = 0; k < 40 && init_done_out !== 1'b1; k++) begin
      @(posedge sys_clk_in);
      #1;
    end
    `CHK(init_done_out, 1'b1)
  endtask

  initial begin
    rst_b_in     = 1'b0;
    ce_in        = 1'b1;
    reg_addr_in  = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    num_errors   = 0;
    n_checks     = 0;
    cycles       = 0;
    defs = '{16'h0190, 16'h0190, 16'h0019, 16'h0032, 16'h0032, 16'h0032};
    do_reset();
    // Before the engine is started nothing is loaded
    rd(OFF_ENGINE_STATUS, rdv);
    `CHK(rdv, 8'h00)
    // Trim written before init must survive a write dropped during loading
    wr(OFF_ACCEL_X_ST_LO, 8'h11);
    wr(OFF_ENGINE_CTRL, 8'h01);
    rd(OFF_ENGINE_STATUS, rdv);
    `CHK(rdv, 8'h02)
    wr(OFF_ACCEL_X_ST_LO, 8'h77);
    wait_init();
    rd(OFF_ENGINE_STATUS, rdv);
    `CHK(rdv, 8'h01)
    rd(OFF_ACCEL_X_ST_LO, rdv);
    `CHK(rdv, 8'h11)
    // Every rate default, low byte at the even address
    for (int i = 0; i < 6; i++) begin
      rd(OFF_FREEFALL_LO + 8'(2 * i), rdv);
      `CHK(rdv, defs[i][7:0])
      rd(OFF_FREEFALL_LO + 8'(2 * i + 1), rdv);
      `CHK(rdv, defs[i][15:8])
    end
    `CHK(params_out.freefall_rate, 16'sd400)
    `CHK(params_out.tap_rate, 16'sd400)
    `CHK(params_out.raise_wake_rate, 16'sd25)
    `CHK(params_out.three_axis_rate, 16'sd50)
    `CHK(params_out.tilt_rate, 16'sd50)
    `CHK(params_out.step_counter_rate, 16'sd50)
    // Read data stands one cycle only
    @(posedge sys_clk_in);
    #1;
    `CHK(reg_rdata_out, 8'h00)
    // Gain high bytes keep four bits
    wr(OFF_GYRO_Y_GAIN_HI, 8'hff);
    `CHK(params_out.gyro_y_gain_trim[11:8], 4'hf)
    rd(OFF_GYRO_Y_GAIN_HI, rdv);
    `CHK(rdv, 8'h0f)
    wr(OFF_GYRO_Z_GAIN_LO, 8'ha5);
    wr(OFF_GYRO_Z_GAIN_HI, 8'h3c);
    `CHK(params_out.gyro_z_gain_trim, 12'hca5)
    rd(OFF_GYRO_Z_GAIN_HI, rdv);
    `CHK(rdv, 8'h0c)
    rd(OFF_GYRO_Z_GAIN_LO, rdv);
    `CHK(rdv, 8'ha5)
    // Self-test words, low byte first; sensor is off so rewrites are allowed
    for (int i = 0; i < 6; i++) begin
      wr(OFF_ACCEL_X_ST_LO + 8'(i), 8'h81 + 8'(i));
    end
    `CHK(params_out.accel_x_selftest_response, 16'h8281)
    `CHK(params_out.accel_y_selftest_response, 16'h8483)
    `CHK(params_out.accel_z_selftest_response, 16'h8685)
    rd(OFF_ACCEL_Z_ST_HI, rdv);
    `CHK(rdv, 8'h86)
    // Clock enable low freezes the bank
    @(posedge sys_clk_in);
    ce_in <= 1'b0;
    wr(OFF_ACCEL_Y_ST_LO, 8'h5a);
    @(posedge sys_clk_in);
    ce_in <= 1'b1;
    rd(OFF_ACCEL_Y_ST_LO, rdv);
    `CHK(rdv, 8'h83)
    // Negative rate and a lone low-byte update
    wr_rd(OFF_TILT_LO, 8'h9c, rdv);
    `CHK(rdv, 8'h9c)
    wr(OFF_TILT_HI, 8'hff);
    `CHK(params_out.tilt_rate, -16'sd100)
    wr(OFF_TAP_LO, 8'h20);
    `CHK(params_out.tap_rate, 16'h0120)
    rd(OFF_TILT_HI, rdv);
    `CHK(rdv, 8'hff)
    // Unmapped place and write-only control read zero
    wr(8'h20, 8'hee);
    rd(8'h20, rdv);
    `CHK(rdv, 8'h00)
    rd(OFF_ENGINE_CTRL, rdv);
    `CHK(rdv, 8'h00)
    // Second reset mid-run clears the done flag, then init runs again
    do_reset();
    wr(OFF_ENGINE_CTRL, 8'h01);
    wait_init();
    rd(OFF_TILT_LO, rdv);
    `CHK(rdv, 8'h32)
    `CHK(params_out.tap_rate, 16'sd400)
    complete_run();
  end

endmodule
